// >>> hdl/pmpc_top.v
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "pmpc_consts.vh"

// Notes on behaviour
// - Power-down request stops the oscillator after the requesting write.
// - Power-down ends on reset, or external interrupt when wake enable set.
// - Reset wake clears registers except the power-off flag; interrupt wake keeps all registers except PD and IDL bits, which clear.
// - Strobes high in idle, low in power-down; port 0 floats externally.
// - Interrupt wake needs enabled level input; low restarts, high completes.
// - Return from wake service resumes after the entering instruction.
// - Power-off flag set at power-on; software may set or clear.
// - Reset ending idle blocks RAM access for two machine cycles.
// - Emulation mode floats port 0, pulls others high, clock runs.
// - Strobe-off suppresses address strobe except during external accesses.
// - Control bit 7 doubles baud; bit 6 selects framing-error function.
// - Power-down bit sets only when watchdog input high; bit 0 idles.
// - Two 16-bit data pointers; select bit chooses active one.
// - Auxiliary register 1 bit 2 ignores writes and reads zero.
// - Pointer instructions act on the currently selected pointer.
// - Selected pointer bytes readable and writable individually.
// - Idle ends on enabled interrupt or hardware reset.
module pmpc_top (
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_reset_n,
	// Avalon-MM slave
	input  wire [9:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	// Pins and core status
	input  wire        i_power_on_det,
	input  wire        i_rst_pin,
	input  wire        i_ale_in,
	input  wire        i_program_fetch_strobe_in,
	input  wire        i_irq_zero_n,
	input  wire        i_irq_one_n,
	input  wire [1:0]  i_irq_enabled,
	input  wire [1:0]  i_irq_level,
	input  wire        i_any_irq,
	input  wire        i_watchdog_enable_input_n,
	input  wire        i_ext_program,
	input  wire        i_ext_access,
	input  wire [7:0]  i_acc,
	input  wire [15:0] i_pc_next,
	// Pointer command port
	input  wire        i_ptr_cmd_valid,
	input  wire [2:0]  i_ptr_cmd,
	input  wire [15:0] i_ptr_data16,
	output reg  [15:0] o_ptr_addr,
	output reg  [15:0] o_resume_pc,
	// Outputs
	output reg         o_osc_run,
	output reg         o_cpu_halt,
	output reg         o_ram_block,
	output reg         o_sfr_reset,
	output reg         o_ale_out,
	output reg         o_ale_oe_n,
	output reg         o_program_fetch_strobe_out,
	output reg         o_program_fetch_strobe_oe_n,
	output reg         o_weak_pull,
	output reg         o_port0_float,
	output reg         o_port2_addr,
	output reg         o_pwm_force_high,
	output reg         o_baud_double,
	output reg         o_framing_sel,
	output reg         o_emul_mode
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	wire [6:0] sync_w;
	pmpc_sync2 #(.W(7)) u_sync (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_power_on_det, i_rst_pin, i_ale_in, i_program_fetch_strobe_in,
		             i_irq_zero_n, i_irq_one_n, i_watchdog_enable_input_n}),
		.o_sync    (sync_w)
	);
	wire por_s  = sync_w[6];
	wire rst_s  = sync_w[5];
	wire ale_s  = sync_w[4];
	wire program_fetch_strobe_s = sync_w[3];
	wire irq0_s = sync_w[2];
	wire irq1_s = sync_w[1];
	wire ew_s   = sync_w[0];

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_RUN  = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_PD   = 2'h2;
	localparam ST_WAKE = 2'h3;

	reg [1:0]  state_q;
	reg [7:0]  power_control_reg_q;
	reg        ao_q;
	reg        dps_q;
	reg        wake_from_powerdown_enable_q;
	reg        aux1_b1_q;
	reg [15:0] dptr0_q;
	reg [15:0] dptr1_q;
	reg        rst_q;
	reg        emul_q;
	reg        guard_on_q;
	reg [7:0]  guard_q;
	reg        pwr_seen_q;

	function [15:0] pmpc_sel;
		input        sel;
		input [15:0] a;
		input [15:0] b;
		begin
			pmpc_sel = sel ? b : a;
		end
	endfunction

	wire [15:0] data_pointer_w   = pmpc_sel(dps_q, dptr0_q, dptr1_q);
	wire [7:0]  idx_w    = i_avs_address[9:2];
	wire        wr_w     = i_avs_write & ~o_avs_waitrequest;
	wire        rd_w     = i_avs_read & ~o_avs_waitrequest;
	wire        irq_wake = (~irq0_s & i_irq_enabled[0] & i_irq_level[0]) |
	                       (~irq1_s & i_irq_enabled[1] & i_irq_level[1]);
	wire        irq_rel  = irq0_s & irq1_s;
	wire        rst_rise = rst_s & ~rst_q;
	wire        rst_fall = ~rst_s & rst_q;

	// ----------------------------------------
	// Power and control registers
	// ----------------------------------------
	always @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q    <= ST_RUN;
			power_control_reg_q     <= `PMPC_POWER_CONTROL_REG_RST;
			ao_q       <= 1'b0;
			dps_q      <= 1'b0;
			wake_from_powerdown_enable_q     <= 1'b0;
			aux1_b1_q  <= 1'b0;
			rst_q      <= 1'b0;
			emul_q     <= 1'b0;
			guard_on_q <= 1'b0;
			guard_q    <= 8'h00;
			pwr_seen_q <= 1'b0;
			o_resume_pc <= 16'h0000;
		end
		else
		begin
			rst_q <= rst_s;
			if (~por_s)
				pwr_seen_q <= 1'b0;
			if (guard_on_q)
			begin
				guard_q <= guard_q - 8'h01;
				if (guard_q == 8'h01)
					guard_on_q <= 1'b0;
			end
			if (rst_s)
			begin
				// Reset clears register state but keeps the power-off flag
				power_control_reg_q    <= `PMPC_POWER_CONTROL_REG_RST | (power_control_reg_q & 8'h20);
				ao_q      <= 1'b0;
				dps_q     <= 1'b0;
				wake_from_powerdown_enable_q    <= 1'b0;
				aux1_b1_q <= 1'b0;
				state_q   <= ST_RUN;
				if (~ale_s & program_fetch_strobe_s)
					emul_q <= 1'b1;
				if (rst_rise & (state_q == ST_IDLE))
				begin
					guard_on_q <= 1'b1;
					guard_q    <= `PMPC_IDLE_GUARD_CY;
				end
			end
			else
			begin
				if (rst_fall & ale_s)
					emul_q <= 1'b0;
				case (state_q)
					ST_RUN:
					begin
						if (wr_w && idx_w == `PMPC_IDX_POWER_CONTROL_REG)
						begin
							power_control_reg_q[7:2] <= i_avs_writedata[7:2];
							power_control_reg_q[`PMPC_POWER_CONTROL_REG_IDL] <= i_avs_writedata[0];
							if (i_avs_writedata[`PMPC_POWER_CONTROL_REG_PD] & ew_s)
							begin
								power_control_reg_q[`PMPC_POWER_CONTROL_REG_PD] <= 1'b1;
								o_resume_pc <= i_pc_next;
								state_q <= ST_PD;
							end
							else if (i_avs_writedata[`PMPC_POWER_CONTROL_REG_IDL])
							begin
								o_resume_pc <= i_pc_next;
								state_q <= ST_IDLE;
							end
						end
						if (wr_w && idx_w == `PMPC_IDX_AUX)
							ao_q <= i_avs_writedata[`PMPC_AUX_AO];
						if (wr_w && idx_w == `PMPC_IDX_AUX1)
						begin
							dps_q     <= i_avs_writedata[`PMPC_AUX1_DPS];
							aux1_b1_q <= i_avs_writedata[1];
							wake_from_powerdown_enable_q    <= i_avs_writedata[`PMPC_AUX1_WAKE_FROM_POWERDOWN_ENABLE];
						end
					end
					ST_IDLE:
					begin
						if (i_any_irq)
						begin
							power_control_reg_q[1:0] <= 2'b00;
							state_q <= ST_RUN;
						end
					end
					ST_PD:
					begin
						if (wake_from_powerdown_enable_q & irq_wake)
							state_q <= ST_WAKE;
					end
					ST_WAKE:
					begin
						if (irq_rel)
						begin
							power_control_reg_q[1:0] <= 2'b00;
							state_q <= ST_RUN;
						end
					end
					default: state_q <= ST_RUN;
				endcase
			end
			// Hardware set of the power-off flag wins over a software write
			if (por_s & ~pwr_seen_q)
			begin
				pwr_seen_q <= 1'b1;
				power_control_reg_q[`PMPC_POWER_CONTROL_REG_POF] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Data pointers
	// ----------------------------------------
	always @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			dptr0_q    <= 16'h0000;
			dptr1_q    <= 16'h0000;
			o_ptr_addr <= 16'h0000;
		end
		else if (rst_s)
		begin
			dptr0_q <= 16'h0000;
			dptr1_q <= 16'h0000;
		end
		else
		begin
			if (i_ptr_cmd_valid)
			begin
				case (i_ptr_cmd)
					`PMPC_CMD_INC:
					begin
						if (dps_q) dptr1_q <= dptr1_q + 16'h0001;
						else dptr0_q <= dptr0_q + 16'h0001;
					end
					`PMPC_CMD_LOAD:
					begin
						if (dps_q) dptr1_q <= i_ptr_data16;
						else dptr0_q <= i_ptr_data16;
					end
					`PMPC_CMD_CODE, `PMPC_CMD_JMP:
						o_ptr_addr <= data_pointer_w + {8'h00, i_acc};
					`PMPC_CMD_XRD, `PMPC_CMD_XWR:
						o_ptr_addr <= data_pointer_w;
					default: o_ptr_addr <= o_ptr_addr;
				endcase
			end
			if (wr_w && idx_w == `PMPC_IDX_DPL && state_q == ST_RUN)
			begin
				if (dps_q) dptr1_q[7:0] <= i_avs_writedata[7:0];
				else dptr0_q[7:0] <= i_avs_writedata[7:0];
			end
			if (wr_w && idx_w == `PMPC_IDX_DPH && state_q == ST_RUN)
			begin
				if (dps_q) dptr1_q[15:8] <= i_avs_writedata[7:0];
				else dptr0_q[15:8] <= i_avs_writedata[7:0];
			end
		end
	end

	// ----------------------------------------
	// Bus answer and pin outputs
	// ----------------------------------------
	reg [31:0] rdata_d;
	always @*
	begin
		rdata_d = 32'h00000000;
		case (idx_w)
			`PMPC_IDX_POWER_CONTROL_REG:   rdata_d = {24'h000000, power_control_reg_q};
			`PMPC_IDX_AUX:    rdata_d = {31'h00000000, ao_q};
			`PMPC_IDX_AUX1:   rdata_d = {28'h0000000, wake_from_powerdown_enable_q, 1'b0, aux1_b1_q, dps_q};
			`PMPC_IDX_DPL:    rdata_d = {24'h000000, data_pointer_w[7:0]};
			`PMPC_IDX_DPH:    rdata_d = {24'h000000, data_pointer_w[15:8]};
			`PMPC_IDX_STATUS: rdata_d = {26'h0000000, emul_q, guard_on_q, 2'b00, state_q};
			default:          rdata_d = 32'h00000000;
		endcase
	end

	wire in_pd   = (state_q == ST_PD);
	wire in_idle = (state_q == ST_IDLE);

	always @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_avs_readdata    <= 32'h00000000;
			o_avs_waitrequest <= 1'b1;
			o_osc_run         <= 1'b1;
			o_cpu_halt        <= 1'b0;
			o_ram_block       <= 1'b0;
			o_sfr_reset       <= 1'b1;
			o_ale_out         <= 1'b1;
			o_ale_oe_n        <= 1'b1;
			o_program_fetch_strobe_out        <= 1'b1;
			o_program_fetch_strobe_oe_n       <= 1'b1;
			o_weak_pull       <= 1'b0;
			o_port0_float     <= 1'b0;
			o_port2_addr      <= 1'b0;
			o_pwm_force_high  <= 1'b0;
			o_baud_double     <= 1'b0;
			o_framing_sel     <= 1'b0;
			o_emul_mode       <= 1'b0;
		end
		else
		begin
			// One wait cycle, then a one-cycle acknowledge
			o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
			if (rd_w | ~o_avs_waitrequest)
				o_avs_readdata <= o_avs_readdata;
			else
				o_avs_readdata <= rdata_d;
			o_osc_run        <= ~(in_pd & ~(wake_from_powerdown_enable_q & irq_wake));
			o_cpu_halt       <= in_pd | in_idle | (state_q == ST_WAKE) | emul_q;
			o_ram_block      <= guard_on_q;
			o_sfr_reset      <= rst_s;
			o_pwm_force_high <= in_pd | in_idle;
			o_port0_float    <= emul_q | ((in_pd | in_idle) & i_ext_program);
			o_port2_addr     <= in_idle & i_ext_program;
			o_weak_pull      <= emul_q;
			o_emul_mode      <= emul_q;
			o_baud_double    <= power_control_reg_q[`PMPC_POWER_CONTROL_REG_DBL];
			o_framing_sel    <= power_control_reg_q[`PMPC_POWER_CONTROL_REG_FESEL];
			o_ale_oe_n       <= emul_q | rst_s;
			o_program_fetch_strobe_oe_n      <= emul_q | rst_s;
			o_program_fetch_strobe_out       <= ~in_pd;
			if (in_pd)
				o_ale_out <= 1'b0;
			else if (in_idle)
				o_ale_out <= 1'b1;
			else
				o_ale_out <= ~ao_q | i_ext_access;
		end
	end

endmodule

`default_nettype wire

// >>> pkg/pmpc_consts.vh
`ifndef PMPC_CONSTS_VH
`define PMPC_CONSTS_VH

// ----------------------------------------
// Register word offsets (byte address = 4 * index)
// ----------------------------------------
`define PMPC_IDX_POWER_CONTROL_REG      8'h87
`define PMPC_IDX_AUX       8'h8E
`define PMPC_IDX_AUX1      8'hA2
`define PMPC_IDX_DPL       8'h82
`define PMPC_IDX_DPH       8'h83
`define PMPC_IDX_CMD       8'h90
`define PMPC_IDX_STATUS    8'h91
`define PMPC_IDX_PINS      8'h92

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMPC_POWER_CONTROL_REG_DBL      7
`define PMPC_POWER_CONTROL_REG_FESEL    6
`define PMPC_POWER_CONTROL_REG_POF      5
`define PMPC_POWER_CONTROL_REG_WLE      4
`define PMPC_POWER_CONTROL_REG_PD       1
`define PMPC_POWER_CONTROL_REG_IDL      0
`define PMPC_AUX_AO        0
`define PMPC_AUX1_DPS      0
`define PMPC_AUX1_ZERO     2
`define PMPC_AUX1_WAKE_FROM_POWERDOWN_ENABLE     3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMPC_POWER_CONTROL_REG_RST      8'h00
`define PMPC_AUX_RST       8'h00
`define PMPC_AUX1_RST      8'h00

// ----------------------------------------
// Pointer command codes
// ----------------------------------------
`define PMPC_CMD_INC       3'h1
`define PMPC_CMD_LOAD      3'h2
`define PMPC_CMD_CODE      3'h3
`define PMPC_CMD_XRD       3'h4
`define PMPC_CMD_XWR       3'h5
`define PMPC_CMD_JMP       3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMPC_CLK_NS        10
`define PMPC_IDLE_GUARD_NS 240
// Two machine cycles of twelve clocks each
`define PMPC_IDLE_GUARD_CY 8'h18

`endif

// >>> hdl/pmpc_sync2.v
`timescale 1ns/1ns
`default_nettype none

module pmpc_sync2 #(
	parameter W = 1
)(
	// Clock and reset
	input  wire         i_mclk,
	input  wire         i_reset_n,
	// Data
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);

	reg [W-1:0] meta_q;

	always @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_q <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end
		else
		begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

`default_nettype wire

// >>> sim/pmpc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmpc_far_model (
	// Emulator and interrupt source controls
	input  wire logic i_irq0_low,
	input  wire logic i_irq1_low,
	input  wire logic i_ale_low,
	// Device pin drivers
	input  wire logic i_ale_out,
	input  wire logic i_ale_oe_n,
	input  wire logic i_program_fetch_strobe_out,
	input  wire logic i_program_fetch_strobe_oe_n,
	// Resolved pin levels
	output logic      o_irq_zero_n,
	output logic      o_irq_one_n,
	output logic      o_ale_pin,
	output logic      o_program_fetch_strobe_pin
);
	// Released irq lines float up through the pull-up
	assign o_irq_zero_n = !i_irq0_low;
	assign o_irq_one_n  = !i_irq1_low;
	// Emulator overrides the weak ALE pull-up; the program fetch strobe pin has no override
	assign o_ale_pin  = i_ale_low ? 1'b0 : (i_ale_oe_n ? 1'b1 : i_ale_out);
	assign o_program_fetch_strobe_pin = i_program_fetch_strobe_oe_n ? 1'b1 : i_program_fetch_strobe_out;
endmodule
`default_nettype wire

// >>> sim/pmpc_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pmpc_top_checker (
	// Clock, reset and bus
	input wire logic        i_mclk,
	input wire logic        i_reset_n,
	input wire logic [9:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	// Pins and status
	input wire logic        i_rst_pin,
	input wire logic        o_osc_run,
	input wire logic        o_cpu_halt,
	input wire logic        o_ram_block,
	input wire logic        o_sfr_reset,
	input wire logic        o_ale_out,
	input wire logic        o_program_fetch_strobe_out,
	input wire logic        o_pwm_force_high,
	input wire logic        o_port0_float,
	input wire logic        o_weak_pull,
	input wire logic        o_emul_mode,
	input wire logic        o_baud_double,
	input wire logic        o_framing_sel
);
	logic [7:0] guard_q;
	wire        take = !o_avs_waitrequest;
	always_ff @(posedge i_mclk or negedge i_reset_n)
		if (!i_reset_n)
			guard_q <= 8'h00;
		else
			guard_q <= o_ram_block ? guard_q + 8'h01 : 8'h00;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	property p_wait_one; take |=> o_avs_waitrequest; endproperty
	property p_wait_cause; $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write);
	endproperty
	property p_pd_halt; !o_osc_run |-> o_cpu_halt; endproperty
	property p_pd_pins; !o_osc_run |-> !o_ale_out && !o_program_fetch_strobe_out && o_pwm_force_high;
	endproperty
	property p_emul; o_emul_mode |-> o_port0_float && o_weak_pull && o_osc_run; endproperty
	property p_sfr_rst; i_rst_pin [*4] |-> o_sfr_reset; endproperty
	property p_ctl_bits; take && i_avs_write && i_avs_address[9:2] == 8'h87 |-> ##2
		o_baud_double == $past(i_avs_writedata[7], 2) &&
		o_framing_sel == $past(i_avs_writedata[6], 2);
	endproperty
	property p_aux1_zero; take && i_avs_read && i_avs_address[9:2] == 8'hA2 |->
		!o_avs_readdata[2]; endproperty
	property p_ram_guard; guard_q <= 8'h18; endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	a_wait_cause: assert property (p_wait_cause) else $error("accept without request");
	a_pd_halt: assert property (p_pd_halt) else $error("clock stopped while running");
	a_pd_pins: assert property (p_pd_pins) else $error("power-down pin state");
	a_emul: assert property (p_emul) else $error("emulation pin state");
	a_sfr_rst: assert property (p_sfr_rst) else $error("reset pin not seen");
	a_ctl_bits: assert property (p_ctl_bits) else $error("serial control bits");
	a_aux1_zero: assert property (p_aux1_zero) else $error("aux1 bit 2 not zero");
	a_ram_guard: assert property (p_ram_guard) else $error("ram guard too long");
	c_pd: cover property ($fell(o_osc_run));
	c_emul: cover property ($rose(o_emul_mode));
	c_guard: cover property ($rose(o_ram_block));
endmodule
bind pmpc_top pmpc_top_checker pmpc_top_checker_i (.i_mclk, .i_reset_n, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
	.i_rst_pin, .o_osc_run, .o_cpu_halt, .o_ram_block, .o_sfr_reset, .o_ale_out,
	.o_program_fetch_strobe_out, .o_pwm_force_high, .o_port0_float, .o_weak_pull, .o_emul_mode,
	.o_baud_double, .o_framing_sel);
`default_nettype wire

// >>> sim/tb_pmpc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmpc_consts.vh"
module tb_pmpc_top;
	// ----------------
	// Signals
	// ----------------
	logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [9:0]  i_avs_address = 10'h000;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
	logic        i_power_on_det = 1'b0, i_rst_pin = 1'b0, i_any_irq = 1'b0, irq0 = 1'b0;
	logic        i_watchdog_enable_input_n = 1'b1, i_ext_program = 1'b0, ale_low = 1'b0;
	logic        i_ptr_cmd_valid = 1'b0, i_ext_access = 1'b0;
	logic [1:0]  i_irq_enabled = 2'h0, i_irq_level = 2'h0;
	logic [7:0]  i_acc = 8'h00;
	logic [15:0] i_pc_next = 16'h0000, i_ptr_data16 = 16'h0000, o_ptr_addr, o_resume_pc;
	logic [2:0]  i_ptr_cmd = 3'h0;
	logic        o_avs_waitrequest, o_osc_run, o_cpu_halt, o_ram_block, o_sfr_reset;
	logic        o_ale_out, o_ale_oe_n, o_program_fetch_strobe_out, o_program_fetch_strobe_oe_n, o_weak_pull, o_port0_float;
	logic        o_port2_addr, o_pwm_force_high, o_baud_double, o_framing_sel, o_emul_mode;
	logic        i_irq_zero_n, i_irq_one_n, i_ale_in, i_program_fetch_strobe_in;
	int          miscompares = 0, compares = 0, n;
	pmpc_top pmpc_top_i (.i_mclk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_power_on_det, .i_rst_pin,
		.i_ale_in, .i_program_fetch_strobe_in, .i_irq_zero_n, .i_irq_one_n, .i_irq_enabled, .i_irq_level,
		.i_any_irq, .i_watchdog_enable_input_n, .i_ext_program, .i_ext_access, .i_acc,
		.i_pc_next, .i_ptr_cmd_valid, .i_ptr_cmd, .i_ptr_data16, .o_ptr_addr, .o_resume_pc,
		.o_osc_run, .o_cpu_halt, .o_ram_block, .o_sfr_reset, .o_ale_out, .o_ale_oe_n,
		.o_program_fetch_strobe_out, .o_program_fetch_strobe_oe_n, .o_weak_pull, .o_port0_float, .o_port2_addr,
		.o_pwm_force_high, .o_baud_double, .o_framing_sel, .o_emul_mode);
	pmpc_far_model pmpc_far_model_i (.i_irq0_low(irq0), .i_irq1_low(1'b0), .i_ale_low(ale_low),
		.i_ale_out(o_ale_out), .i_ale_oe_n(o_ale_oe_n), .i_program_fetch_strobe_out(o_program_fetch_strobe_out),
		.i_program_fetch_strobe_oe_n(o_program_fetch_strobe_oe_n), .o_irq_zero_n(i_irq_zero_n), .o_irq_one_n(i_irq_one_n),
		.o_ale_pin(i_ale_in), .o_program_fetch_strobe_pin(i_program_fetch_strobe_in));
	// ----------------
	// Shared tasks
	// ----------------
	task automatic tick(input int k);
		repeat (k) @(posedge i_mclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		@(posedge i_mclk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= {idx, 2'h0};
		i_avs_writedata <= {24'h0, d};
		k = 0;
		do
		begin
			@(posedge i_mclk);
			k++;
		end
		while (o_avs_waitrequest !== 1'b0 && k < 100);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		chk("bus answer", 1, k < 100);
	endtask
	task automatic cmd(input logic [2:0] c, input logic [15:0] d);
		@(posedge i_mclk);
		i_ptr_cmd_valid <= 1'b1;
		i_ptr_cmd <= c;
		i_ptr_data16 <= d;
		@(posedge i_mclk);
		i_ptr_cmd_valid <= 1'b0;
		tick(2);
	endtask
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs;
		bus(0, 8'h10, 8'h00);
		chk("unmapped", 0, q);
		i_power_on_det <= 1'b1;
		tick(6);
		bus(0, `PMPC_IDX_POWER_CONTROL_REG, 8'h00);
		chk("pof", 1, q[5]);
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'hC0);
		bus(0, `PMPC_IDX_POWER_CONTROL_REG, 8'h00);
		chk("power_control_reg", 3'h6, q[7:5]);
		chk("baud", 2'h3, {o_baud_double, o_framing_sel});
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h20);
		bus(0, `PMPC_IDX_POWER_CONTROL_REG, 8'h00);
		chk("pof set", 8'h20, q);
		bus(1, `PMPC_IDX_AUX, 8'h01);
		tick(2);
		chk("ale off", 0, o_ale_out);
		i_ext_access <= 1'b1;
		tick(2);
		chk("ale access", 1, o_ale_out);
		i_ext_access <= 1'b0;
		tick(2);
		chk("ale off again", 0, o_ale_out);
		bus(1, `PMPC_IDX_AUX, 8'h00);
	endtask
	task automatic t_ptr;
		bus(1, `PMPC_IDX_DPL, 8'h34);
		bus(1, `PMPC_IDX_DPH, 8'h12);
		bus(1, `PMPC_IDX_AUX1, 8'h01);
		cmd(`PMPC_CMD_LOAD, 16'hFFFF);
		cmd(`PMPC_CMD_INC, 16'h0000);
		cmd(`PMPC_CMD_XRD, 16'h0000);
		chk("inc wrap", 16'h0000, o_ptr_addr);
		bus(0, `PMPC_IDX_AUX1, 8'h00);
		bus(1, `PMPC_IDX_AUX1, q[7:0] + 8'h01);
		bus(0, `PMPC_IDX_AUX1, 8'h00);
		chk("aux1", 2'h0, {q[2], q[0]});
		bus(0, `PMPC_IDX_DPL, 8'h00);
		chk("dpl", 8'h34, q[7:0]);
		bus(0, `PMPC_IDX_DPH, 8'h00);
		chk("dph", 8'h12, q[7:0]);
		i_acc <= 8'h03;
		cmd(`PMPC_CMD_CODE, 16'h0000);
		chk("code", 16'h1237, o_ptr_addr);
		cmd(`PMPC_CMD_LOAD, 16'hABCD);
		cmd(`PMPC_CMD_JMP, 16'h0000);
		chk("jmp", 16'hABD0, o_ptr_addr);
		cmd(`PMPC_CMD_XWR, 16'h0000);
		chk("xwr", 16'hABCD, o_ptr_addr);
	endtask
	task automatic t_pd_irq;
		i_watchdog_enable_input_n <= 1'b0;
		tick(5);
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h02);
		tick(20);
		chk("no pd", 1, o_osc_run);
		i_watchdog_enable_input_n <= 1'b1;
		i_pc_next <= 16'h1234;
		i_irq_enabled <= 2'h1;
		i_irq_level <= 2'h1;
		bus(1, `PMPC_IDX_AUX1, 8'h08);
		tick(5);
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h83);
		for (n = 0; n < 50 && o_osc_run !== 1'b0; n++) tick(1);
		chk("pd", 0, o_osc_run);
		chk("pins", 3'h1, {o_ale_out, o_program_fetch_strobe_out, o_pwm_force_high});
		irq0 <= 1'b1;
		for (n = 0; n < 100 && o_osc_run !== 1'b1; n++) tick(1);
		chk("restart", 1, o_osc_run);
		tick(30);
		irq0 <= 1'b0;
		for (n = 0; n < 100 && o_cpu_halt !== 1'b0; n++) tick(1);
		chk("awake", 0, o_cpu_halt);
		chk("resume", 16'h1234, o_resume_pc);
		bus(0, `PMPC_IDX_POWER_CONTROL_REG, 8'h00);
		chk("power_control_reg kept", 3'h4, {q[7], q[1:0]});
	endtask
	task automatic t_pd_rst;
		bus(1, `PMPC_IDX_AUX1, 8'h00);
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h82);
		for (n = 0; n < 50 && o_osc_run !== 1'b0; n++) tick(1);
		irq0 <= 1'b1;
		tick(40);
		chk("no wake", 0, o_osc_run);
		irq0 <= 1'b0;
		i_rst_pin <= 1'b1;
		tick(10);
		chk("rst wake", 2'h3, {o_osc_run, o_sfr_reset});
		i_rst_pin <= 1'b0;
		tick(10);
		chk("sfr cleared", 0, o_baud_double);
	endtask
	task automatic t_idle;
		i_ext_program <= 1'b1;
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h01);
		tick(4);
		chk("idle", 5'h1F, {o_cpu_halt, o_ale_out, o_program_fetch_strobe_out, o_port0_float, o_port2_addr});
		chk("pwm", 1, o_pwm_force_high);
		i_any_irq <= 1'b1;
		for (n = 0; n < 50 && o_cpu_halt !== 1'b0; n++) tick(1);
		chk("irq end", 0, o_cpu_halt);
		i_any_irq <= 1'b0;
		i_ext_program <= 1'b0;
		bus(1, `PMPC_IDX_POWER_CONTROL_REG, 8'h01);
		tick(4);
		i_rst_pin <= 1'b1;
		for (n = 0; n < 10 && o_ram_block !== 1'b1; n++) tick(1);
		chk("guard", 1, o_ram_block);
		tick(40);
		i_rst_pin <= 1'b0;
		chk("guard end", 0, o_ram_block);
		tick(10);
	endtask
	task automatic t_emul;
		i_rst_pin <= 1'b1;
		ale_low <= 1'b1;
		tick(10);
		i_rst_pin <= 1'b0;
		tick(10);
		ale_low <= 1'b0;
		tick(2);
		chk("emul", 4'hF, {o_emul_mode, o_port0_float, o_weak_pull, o_osc_run});
		i_rst_pin <= 1'b1;
		tick(10);
		i_rst_pin <= 1'b0;
		tick(10);
		chk("normal", 0, o_emul_mode);
	endtask
	// ----------------
	// Run
	// ----------------
	initial forever #5 i_mclk = ~i_mclk;
	initial
	begin
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		t_regs;
		t_ptr;
		t_pd_irq;
		t_pd_rst;
		t_idle;
		t_emul;
		stop_test;
	end
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		stop_test;
	end
endmodule
`default_nettype wire
